// >>> sri_regs.svh
`ifndef SRI_REGS_SVH
`define SRI_REGS_SVH

// ----------------------------------------------------------------
// Register index on the plain register port
// ----------------------------------------------------------------
`define SRI_REG_CTRL      4'h0
`define SRI_REG_STAT      4'h1
`define SRI_REG_MASK      4'h2
`define SRI_REG_AISGEN    4'h3
`define SRI_REG_AISDET    4'h4
`define SRI_REG_STUFFE    4'h5
`define SRI_REG_PROTMAP   4'h6
`define SRI_REG_PMCNT     4'h7
`define SRI_REG_LIVE      4'h8

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define SRI_CTRL_PCLK     0
`define SRI_CTRL_PDATA    1
`define SRI_CTRL_XBIT     2
`define SRI_CTRL_W        3

// ----------------------------------------------------------------
// Status and mask fields
// ----------------------------------------------------------------
`define SRI_ST_CLK        0
`define SRI_ST_SYNC       2
`define SRI_ST_PAR        4
`define SRI_ST_STUFF      6
`define SRI_ST_AIS        7
`define SRI_ST_XBIT       8
`define SRI_ST_W          9

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SRI_CTRL_RST      3'h0
`define SRI_MASK_RST      9'h000
`define SRI_TRIB_RST      28'h000_0000

// ----------------------------------------------------------------
// Framing and timing
// ----------------------------------------------------------------
`define SRI_TRIBS         28
`define SRI_HALF          14
`define SRI_BLK_BITS      16
`define SRI_XBIT_POS      14
`define SRI_LAST_BIT      4'hF
`define SRI_LAST_BLK      4'hD
`define SRI_FRAME_BITS    9'h0E0
`define SRI_LINK_KBPS     27648
`define SRI_SYNC_HZ       123429
`define SRI_SYS_MHZ       50
`define SRI_CLK_LOSS_NS   1000
`define SRI_CLK_LOSS_CYC  ((`SRI_CLK_LOSS_NS * `SRI_SYS_MHZ + 999) / 1000)

`endif

// >>> sri_pkg.sv
package sri_pkg;
`include "sri_regs.svh"

   typedef logic [`SRI_TRIBS-1:0]    sri_trib_type;
   typedef logic [`SRI_HALF-1:0]     sri_half_type;
   typedef logic [`SRI_BLK_BITS-1:0] sri_blk_type;

   // ----------------------------------------------------------------
   // Block checker state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [`SRI_BLK_BITS-2:0] sh;
      sri_blk_type              word;
      logic                     vld;
      logic                     perr;
   } sri_chk_type;

   // ----------------------------------------------------------------
   // Core state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [`SRI_CTRL_W-1:0] ctrl;
      logic [`SRI_ST_W-1:0]   stat;
      logic [`SRI_ST_W-1:0]   mask;
      sri_trib_type           aisgen;
      sri_trib_type           aisdet;
      sri_trib_type           stuffe;
      sri_trib_type           protmap;
      logic [15:0]            pmcnt;
      logic [31:0]            rdata;
      logic                   irq;
      logic [1:0]             clk_prev;
      logic [1:0][7:0]        wd;
      logic [1:0]             clk_lost;
      logic [1:0]             sync_prev;
      logic [1:0][8:0]        scnt;
      logic [1:0]             sync_lost;
      logic [3:0]             bit_idx;
      logic [3:0]             blk_idx;
      sri_blk_type            tx_sh_lo;
      sri_blk_type            tx_sh_up;
      logic                   tx_lo;
      logic                   tx_up;
      sri_trib_type           tx_par;
      sri_trib_type           rx_par;
      sri_trib_type           zero_seen;
      sri_half_type           trib_a;
      sri_half_type           trib_b;
   } sri_state_type;

endpackage

// >>> sri_sync2.sv
`timescale 1ns/100ps

module sri_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,  // System clock
   input  wire logic         rst_n,    // Synchronous reset
   input  wire logic         ce,       // Clock enable
   input  wire logic [W-1:0] din,      // Asynchronous inputs
   output wire logic [W-1:0] dout      // Synchronised inputs
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sri_sync_type;

   sri_sync_type s;
   sri_sync_type n;

   // First stage feeds only the second stage
   always_comb begin
      n    = s;
      n.s1 = din;
      n.s2 = s.s1;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s <= '0;
      end else if (ce) begin
         s <= n;
      end
   end

   assign dout = s.s2;

endmodule

// >>> sri_blk_chk.sv
`timescale 1ns/100ps

module sri_blk_chk
   import sri_pkg::*;
(
   input  wire logic        clk_sys,  // System clock
   input  wire logic        rst_n,    // Synchronous reset
   input  wire logic        ce,       // Clock enable
   input  wire logic        tick,     // Link bit strobe
   input  wire logic [3:0]  pos,      // Bit position in block
   input  wire logic        bit_in,   // Serial data bit
   output wire sri_blk_type word,     // Last complete block
   output wire logic        vld,      // Block done, one cycle
   output wire logic        perr      // Block parity wrong
);

   sri_chk_type s;
   sri_chk_type n;

   // ----------------------------------------------------------------
   // Deserialise and check even parity over the whole block
   // ----------------------------------------------------------------
   always_comb begin
      n      = s;
      n.vld  = 1'b0;
      n.perr = 1'b0;
      if (tick) begin
         if (pos == `SRI_LAST_BIT) begin
            n.word = {bit_in, s.sh};
            n.vld  = 1'b1;
            n.perr = ^{bit_in, s.sh};
         end else begin
            n.sh[pos] = bit_in;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s <= '0;
      end else if (ce) begin
         s <= n;
      end
   end

   assign word = s.word;
   assign vld  = s.vld;
   assign perr = s.perr;

endmodule

// >>> sri_core.sv
`timescale 1ns/100ps
`include "sri_regs.svh"

module sri_core
   import sri_pkg::*;
(
   input  wire logic               clk_sys,    // System clock, 50 MHz
   input  wire logic               rst_n,      // Synchronous reset
   input  wire logic               ce,         // Clock enable
   input  wire logic [3:0]         reg_addr,   // Register index
   input  wire logic [31:0]        reg_wdata,  // Write data
   input  wire logic               reg_wr,     // Write strobe
   input  wire logic               reg_rd,     // Read strobe
   output wire logic [31:0]        reg_rdata,  // Read data, next cycle
   output wire logic               irq,        // Interrupt level
   input  wire logic               lclk_svc,   // Service link clock
   input  wire logic               lclk_prt,   // Protection link clock
   input  wire logic               lsync_svc,  // Service frame sync
   input  wire logic               lsync_prt,  // Protection frame sync
   input  wire logic               rx_svc_lo,  // Service lower data in
   input  wire logic               rx_svc_up,  // Service upper data in
   input  wire logic               rx_prt_lo,  // Protection lower data in
   input  wire logic               rx_prt_up,  // Protection upper data in
   output wire logic               tx_svc_lo,  // Service lower data out
   output wire logic               tx_svc_up,  // Service upper data out
   output wire logic               tx_prt_lo,  // Protection lower out
   output wire logic               tx_prt_up,  // Protection upper out
   input  wire sri_half_type       trib_a_rx,  // Card A tributaries in
   input  wire sri_half_type       trib_b_rx,  // Card B tributaries in
   output wire sri_half_type       trib_a_tx,  // Card A tributaries out
   output wire sri_half_type       trib_b_tx   // Card B tributaries out
);

   localparam logic [7:0] CLK_LOSS_CYC = 8'(`SRI_CLK_LOSS_CYC);
   localparam int         PIN_W        = 8 + `SRI_TRIBS;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic sri_blk_type mk_blk(input sri_half_type d,
                                          input logic xb);
      mk_blk = {^{xb, d}, xb, d};
   endfunction

   function automatic logic [15:0] popcnt(input sri_trib_type v);
      logic [15:0] c;
      c = 16'h0000;
      for (int i = 0; i < `SRI_TRIBS; i++) begin
         c = c + 16'(v[i]);
      end
      popcnt = c;
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [PIN_W-1:0] pin_s;
   logic [1:0]       clk_s;
   logic [1:0]       sync_s;
   logic [3:0]       rx_s;
   sri_trib_type     trib_s;

   sri_sync2 #(.W(PIN_W)) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .ce      (ce),
      .din     ({trib_b_rx, trib_a_rx, rx_prt_up, rx_prt_lo,
                 rx_svc_up, rx_svc_lo, lsync_prt, lsync_svc,
                 lclk_prt, lclk_svc}),
      .dout    (pin_s)
   );

   assign clk_s  = pin_s[1:0];
   assign sync_s = pin_s[3:2];
   assign rx_s   = pin_s[7:4];
   assign trib_s = pin_s[PIN_W-1:8];

   // ----------------------------------------------------------------
   // Framing strobes
   // ----------------------------------------------------------------
   sri_state_type s;
   sri_state_type n;
   logic [1:0]    edge_v;
   logic          sel_clk;
   logic          tick;
   logic          fstart;
   logic [3:0]    cur_bit;
   logic [3:0]    cur_blk;

   assign edge_v  = clk_s & ~s.clk_prev;
   assign sel_clk = s.ctrl[`SRI_CTRL_PCLK];
   assign tick    = edge_v[sel_clk];
   assign fstart  = tick & sync_s[sel_clk] & ~s.sync_prev[sel_clk];
   assign cur_bit = fstart ? 4'h0 : s.bit_idx;
   assign cur_blk = fstart ? 4'h0 : s.blk_idx;

   // ----------------------------------------------------------------
   // Incoming block checkers: 0 svc lo, 1 svc up, 2 prt lo, 3 prt up
   // ----------------------------------------------------------------
   sri_blk_type [3:0] chk_word;
   logic [3:0]        chk_vld;
   logic [3:0]        chk_perr;

   for (genvar g = 0; g < 4; g++) begin : g_chk
      sri_blk_chk u_chk (
         .clk_sys (clk_sys),
         .rst_n   (rst_n),
         .ce      (ce),
         .tick    (tick),
         .pos     (cur_bit),
         .bit_in  (rx_s[g]),
         .word    (chk_word[g]),
         .vld     (chk_vld[g]),
         .perr    (chk_perr[g])
      );
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic [`SRI_ST_W-1:0] ev;
   logic [`SRI_ST_W-1:0] st_clr;
   sri_trib_type         sf_clr;
   sri_trib_type         sf_set;
   sri_trib_type         zs;
   sri_trib_type         dat;
   sri_trib_type         rxd;
   sri_trib_type         mis;
   sri_blk_type          wl;
   sri_blk_type          wu;
   logic                 pm_clr;
   logic [15:0]          pm_add;
   logic                 pd;
   logic                 xb;

   always_comb begin
      n       = s;
      ev      = '0;
      st_clr  = '0;
      sf_clr  = '0;
      sf_set  = '0;
      zs      = '0;
      dat     = '0;
      rxd     = '0;
      mis     = '0;
      wl      = '0;
      wu      = '0;
      pm_clr  = 1'b0;
      pm_add  = 16'h0000;
      pd      = s.ctrl[`SRI_CTRL_PDATA];
      xb      = s.ctrl[`SRI_CTRL_XBIT];
      n.rdata = 32'h0000_0000;

      // Clock and sync supervision on both copies
      for (int i = 0; i < 2; i++) begin
         if (edge_v[i]) begin
            n.wd[i]        = 8'h00;
            n.sync_prev[i] = sync_s[i];
            if (sync_s[i] && !s.sync_prev[i])
               n.scnt[i] = 9'h000;
            else if (s.scnt[i] != 9'h1FF)
               n.scnt[i] = s.scnt[i] + 9'h001;
         end else if (s.wd[i] != 8'hFF) begin
            n.wd[i] = s.wd[i] + 8'h01;
         end
         n.clk_lost[i]          = n.wd[i] >= CLK_LOSS_CYC;
         n.sync_lost[i]         = n.scnt[i] >= `SRI_FRAME_BITS;
         ev[`SRI_ST_CLK + i]  = n.clk_lost[i] & ~s.clk_lost[i];
         ev[`SRI_ST_SYNC + i] = n.sync_lost[i] & ~s.sync_lost[i];
      end
      n.clk_prev = clk_s;

      // Transmit toward the switch
      if (tick) begin
         n.bit_idx = cur_bit + 4'h1;
         if (cur_bit == `SRI_LAST_BIT)
            n.blk_idx = (cur_blk == `SRI_LAST_BLK) ? 4'h0 : cur_blk + 4'h1;
         else
            n.blk_idx = cur_blk;
         if (cur_bit == 4'h0) begin
            zs = s.zero_seen | ~trib_s;
            if (cur_blk == `SRI_LAST_BLK) begin
               dat         = s.tx_par;
               n.tx_par    = '0;
               n.aisdet    = ~zs;
               ev[`SRI_ST_AIS] = |(~zs & ~s.aisdet);
               n.zero_seen = '0;
            end else begin
               dat         = trib_s | s.aisgen;
               n.tx_par    = s.tx_par ^ dat;
               n.zero_seen = zs;
            end
            n.tx_sh_lo = mk_blk(dat[`SRI_HALF-1:0], xb);
            n.tx_sh_up = mk_blk(dat[`SRI_TRIBS-1:`SRI_HALF], xb);
            n.tx_lo    = n.tx_sh_lo[0];
            n.tx_up    = n.tx_sh_up[0];
         end else begin
            n.tx_lo = s.tx_sh_lo[cur_bit];
            n.tx_up = s.tx_sh_up[cur_bit];
         end
      end

      // Receive from the switch
      if (chk_vld[0]) begin
         ev[`SRI_ST_PAR]     = chk_perr[0] | chk_perr[1];
         ev[`SRI_ST_PAR + 1] = chk_perr[2] | chk_perr[3];
         wl  = chk_word[{pd, 1'b0}];
         wu  = chk_word[{pd, 1'b1}];
         rxd = {wu[`SRI_HALF-1:0], wl[`SRI_HALF-1:0]};
         ev[`SRI_ST_XBIT] = (wl[`SRI_XBIT_POS] != xb) |
                            (wu[`SRI_XBIT_POS] != xb);
         // Block just finished was the stuff block
         if (s.blk_idx == 4'h0) begin
            mis    = rxd ^ s.rx_par;
            sf_set = mis;
            ev[`SRI_ST_STUFF] = |mis;
            pm_add = popcnt(mis & ~s.protmap);
            n.rx_par = '0;
         end else begin
            n.trib_a = wl[`SRI_HALF-1:0];
            n.trib_b = wu[`SRI_HALF-1:0];
            n.rx_par = s.rx_par ^ rxd;
         end
      end

      // Register writes
      if (reg_wr) begin
         case (reg_addr)
            `SRI_REG_CTRL:    n.ctrl    = reg_wdata[`SRI_CTRL_W-1:0];
            `SRI_REG_MASK:    n.mask    = reg_wdata[`SRI_ST_W-1:0];
            `SRI_REG_AISGEN:  n.aisgen  = reg_wdata[`SRI_TRIBS-1:0];
            `SRI_REG_PROTMAP: n.protmap = reg_wdata[`SRI_TRIBS-1:0];
            `SRI_REG_STAT:    st_clr    = reg_wdata[`SRI_ST_W-1:0];
            `SRI_REG_STUFFE:  sf_clr    = reg_wdata[`SRI_TRIBS-1:0];
            `SRI_REG_PMCNT:   pm_clr    = 1'b1;
            default: ;
         endcase
      end

      // Sticky bits: a new event beats a clear in the same cycle
      n.stat   = (s.stat & ~st_clr) | ev;
      n.stuffe = (s.stuffe & ~sf_clr) | sf_set;
      n.pmcnt  = (pm_clr ? 16'h0000 : s.pmcnt) + pm_add;
      n.irq    = |(n.stat & n.mask);

      // Register reads
      if (reg_rd) begin
         case (reg_addr)
            `SRI_REG_CTRL:    n.rdata = 32'(s.ctrl);
            `SRI_REG_STAT:    n.rdata = 32'(s.stat);
            `SRI_REG_MASK:    n.rdata = 32'(s.mask);
            `SRI_REG_AISGEN:  n.rdata = 32'(s.aisgen);
            `SRI_REG_AISDET:  n.rdata = 32'(s.aisdet);
            `SRI_REG_STUFFE:  n.rdata = 32'(s.stuffe);
            `SRI_REG_PROTMAP: n.rdata = 32'(s.protmap);
            `SRI_REG_PMCNT:   n.rdata = 32'(s.pmcnt);
            `SRI_REG_LIVE:    n.rdata = 32'({s.sync_lost, s.clk_lost});
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s <= '0;
      end else if (ce) begin
         s <= n;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign reg_rdata = s.rdata;
   assign irq       = s.irq;
   assign tx_svc_lo = s.tx_lo;
   assign tx_prt_lo = s.tx_lo;
   assign tx_svc_up = s.tx_up;
   assign tx_prt_up = s.tx_up;
   assign trib_a_tx = s.trib_a;
   assign trib_b_tx = s.trib_b;

endmodule

// >>> sri_core_sva.sv
`timescale 1ns/100ps
module sri_core_sva
   import sri_pkg::*;
(
   input wire logic         clk_sys,    // System clock
   input wire logic         rst_n,      // Synchronous reset
   input wire logic [3:0]   reg_addr,   // Register index
   input wire logic         reg_wr,     // Write strobe
   input wire logic         reg_rd,     // Read strobe
   input wire logic [31:0]  reg_rdata,  // Read data
   input wire logic         irq,        // Interrupt level
   input wire logic         lclk_svc,   // Service link clock
   input wire logic         lclk_prt,   // Protection link clock
   input wire logic         tx_svc_lo,  // Service lower out
   input wire logic         tx_svc_up,  // Service upper out
   input wire logic         tx_prt_lo,  // Protection lower out
   input wire logic         tx_prt_up,  // Protection upper out
   input wire sri_half_type trib_a_tx,  // Card A out
   input wire sri_half_type trib_b_tx   // Card B out
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------------
   // Link side
   // ----------------------------------------------------------------
   lo_pair_a: assert property (tx_svc_lo == tx_prt_lo)
      else $error("lower outputs differ");
   up_pair_a: assert property (tx_svc_up == tx_prt_up)
      else $error("upper outputs differ");
   // Bits only move after a sampled link edge, so a quiet link freezes
   // A half link period holds four samples, so three stable ones fit
   tx_quiet_a: assert property (
      ($stable(lclk_svc) && $stable(lclk_prt)) [*3]
      |=> $stable(tx_svc_lo) && $stable(tx_svc_up))
      else $error("serial output moved without link edge");
   // Tributary outputs trail the serial bits by one block check cycle
   trib_quiet_a: assert property (
      ($stable(lclk_svc) && $stable(lclk_prt)) [*3]
      |=> ##1 $stable(trib_a_tx) && $stable(trib_b_tx))
      else $error("tributary output moved without link edge");
   reset_clear_a: assert property ($rose(rst_n) |-> !irq && !tx_svc_lo
      && !tx_svc_up && trib_a_tx == '0 && trib_b_tx == '0)
      else $error("outputs not cleared by reset");
   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data outside read slot");
   unmapped_rd_a: assert property (reg_rd && reg_addr > 4'h8
      |=> reg_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   irq_fall_a: assert property ($fell(irq) |-> $past(reg_wr))
      else $error("interrupt dropped without a write");
endmodule

bind sri_core sri_core_sva u_sri_core_sva (.clk_sys(clk_sys), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .irq(irq), .lclk_svc(lclk_svc),
   .lclk_prt(lclk_prt), .tx_svc_lo(tx_svc_lo), .tx_svc_up(tx_svc_up),
   .tx_prt_lo(tx_prt_lo), .tx_prt_up(tx_prt_up), .trib_a_tx(trib_a_tx),
   .trib_b_tx(trib_b_tx));

// >>> sri_sw_model.sv
`timescale 1ns/100ps
module sri_sw_model (
   input  wire logic       svc_run,    // Service clock running
   input  wire logic       sync_run,   // Frame sync running
   input  wire logic [1:0] fault,      // 1 one bit, 2 all bits
   input  wire logic       tx_svc_lo,  // Service lower in
   input  wire logic       tx_svc_up,  // Service upper in
   input  wire logic       tx_prt_lo,  // Protection lower in
   input  wire logic       tx_prt_up,  // Protection upper in
   output wire logic       lclk_svc,   // Service link clock
   output wire logic       lclk_prt,   // Protection link clock
   output wire logic       lsync_svc,  // Service frame sync
   output wire logic       lsync_prt,  // Protection frame sync
   output wire logic       rx_svc_lo,  // Service lower out
   output wire logic       rx_svc_up,  // Service upper out
   output wire logic       rx_prt_lo,  // Protection lower out
   output wire logic       rx_prt_up   // Protection upper out
);
   logic         lclk = 1'b0;
   logic         sync = 1'b0;
   logic [7:0]   pos  = 8'h00;
   logic [223:0] sl   = '0;
   logic [223:0] su   = '0;
   logic [223:0] pl   = '0;
   logic [223:0] pu   = '0;
   // Odd start keeps link edges off the system clock edges
   initial begin
      #7;
      forever #80 lclk = ~lclk;
   end
   assign lclk_prt  = lclk;
   assign lclk_svc  = lclk & svc_run;
   assign lsync_svc = sync & sync_run;
   assign lsync_prt = sync & sync_run;
   always @(negedge lclk) begin
      sync <= (pos == 8'h00);
   end
   always @(posedge lclk) begin
      pos <= (pos == 8'hDF) ? 8'h00 : pos + 8'h01;
      pl  <= {pl[222:0], tx_prt_lo};
      pu  <= {pu[222:0], tx_prt_up};
   end
   always @(posedge lclk_svc) begin
      sl <= {sl[222:0], tx_svc_lo};
      su <= {su[222:0], tx_svc_up};
   end
   // One frame of delay returns each bit on the local framing
   assign rx_svc_lo = sl[223];
   assign rx_svc_up = su[223];
   assign rx_prt_up = pu[223];
   // Single flip hits block 12, bit 0: first tributary only
   assign rx_prt_lo = pl[223] ^ (fault == 2'd2)
                      ^ (fault == 2'd1 && pos == 8'd193);
endmodule

// >>> tb_top.sv
`timescale 1ns/100ps
`include "sri_regs.svh"
`define CHK(g, e) \
   begin \
      n_tests++; \
      if ((g) !== (e)) begin \
         num_errors++; \
         $display("wrong value at %0t: %h vs %h", $time, g, e); \
      end \
   end
module tb_top
   import sri_pkg::*;
;
   localparam int FRAME_CLK = 1792;
   logic         clk_sys, rst_n, reg_wr, reg_rd, irq;
   logic [3:0]   reg_addr;
   logic [31:0]  reg_wdata, reg_rdata, rv;
   logic         lclk_svc, lclk_prt, lsync_svc, lsync_prt;
   logic         rx_svc_lo, rx_svc_up, rx_prt_lo, rx_prt_up;
   logic         tx_svc_lo, tx_svc_up, tx_prt_lo, tx_prt_up;
   logic         svc_run, sync_run;
   logic [1:0]   fault;
   sri_half_type trib_a_rx, trib_b_rx, trib_a_tx, trib_b_tx;
   int           num_errors, n_tests;

   sri_core u_sri_core (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
      .lclk_svc(lclk_svc), .lclk_prt(lclk_prt), .lsync_svc(lsync_svc),
      .lsync_prt(lsync_prt), .rx_svc_lo(rx_svc_lo), .rx_svc_up(rx_svc_up),
      .rx_prt_lo(rx_prt_lo), .rx_prt_up(rx_prt_up), .tx_svc_lo(tx_svc_lo),
      .tx_svc_up(tx_svc_up), .tx_prt_lo(tx_prt_lo), .tx_prt_up(tx_prt_up),
      .trib_a_rx(trib_a_rx), .trib_b_rx(trib_b_rx),
      .trib_a_tx(trib_a_tx), .trib_b_tx(trib_b_tx));
   sri_sw_model u_sri_sw_model (.svc_run(svc_run), .sync_run(sync_run),
      .fault(fault), .tx_svc_lo(tx_svc_lo), .tx_svc_up(tx_svc_up),
      .tx_prt_lo(tx_prt_lo), .tx_prt_up(tx_prt_up), .lclk_svc(lclk_svc),
      .lclk_prt(lclk_prt), .lsync_svc(lsync_svc), .lsync_prt(lsync_prt),
      .rx_svc_lo(rx_svc_lo), .rx_svc_up(rx_svc_up),
      .rx_prt_lo(rx_prt_lo), .rx_prt_up(rx_prt_up));
   // ----------------------------------------------------------------
   // Register port tasks
   // ----------------------------------------------------------------
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      @(posedge clk_sys);
      rv = reg_rdata;
   endtask
   task automatic frames(input int n);
      repeat (n * FRAME_CLK) @(posedge clk_sys);
   endtask
   task automatic close_out;
      $display("compares %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Clock, watchdog and tests
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (90000) @(posedge clk_sys);
      num_errors++;
      close_out();
   end
   initial begin
      {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, fault} = '0;
      {svc_run, sync_run} = 2'b11;
      {num_errors, n_tests} = '0;
      trib_a_rx = 14'h2A5C;
      trib_b_rx = 14'h1337;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(`SRI_REG_CTRL); `CHK(rv, 32'h0000_0000)
      rd(`SRI_REG_MASK); `CHK(rv, 32'h0000_0000)
      rd(4'hF); `CHK(rv, 32'h0000_0000)
      // Loopback through the switch model, status other than AIS must stay clean
      frames(4);
      wr(`SRI_REG_STAT, 32'h0000_01FF);
      wr(`SRI_REG_STUFFE, 32'h0FFF_FFFF);
      frames(2);
      rd(`SRI_REG_STAT); `CHK(rv & 32'h0000_017F, 32'h0000_0000)
      `CHK(rv[5:4], 2'b00)
      rd(`SRI_REG_STUFFE); `CHK(rv, 32'h0000_0000)
      `CHK(trib_a_tx, 14'h2A5C)
      `CHK(trib_b_tx, 14'h1337)
      rd(`SRI_REG_AISDET); `CHK(rv, {4'h0, trib_b_rx, trib_a_rx})
      wr(`SRI_REG_AISGEN, 32'h0000_0001);
      frames(3);
      `CHK(trib_a_tx, 14'h2A5D)
      // Changed check bit mismatches on the frame still in flight
      wr(`SRI_REG_CTRL, 32'h0000_0004);
      frames(2);
      rd(`SRI_REG_STAT); `CHK(rv[8], 1'b1)
      `CHK(irq, 1'b0)
      wr(`SRI_REG_STAT, 32'h0000_01FF);
      frames(2);
      rd(`SRI_REG_STAT); `CHK(rv[8], 1'b0)
      // One bad bit per frame on the protection lower line
      wr(`SRI_REG_MASK, 32'h0000_0020);
      fault <= 2'd1;
      frames(2);
      rd(`SRI_REG_STAT); `CHK(rv[5:4], 2'b10)
      `CHK(irq, 1'b1)
      rd(`SRI_REG_STUFFE); `CHK(rv, 32'h0000_0000)
      wr(`SRI_REG_CTRL, 32'h0000_0006);
      wr(`SRI_REG_PMCNT, 32'h0000_0000);
      frames(2);
      rd(`SRI_REG_STUFFE); `CHK(rv, 32'h0000_0001)
      rd(`SRI_REG_PMCNT); `CHK(rv != 32'h0000_0000, 1'b1)
      wr(`SRI_REG_PROTMAP, 32'h0000_0001);
      wr(`SRI_REG_PMCNT, 32'h0000_0000);
      frames(2);
      rd(`SRI_REG_PMCNT); `CHK(rv, 32'h0000_0000)
      fault <= 2'd0;
      frames(1);
      wr(`SRI_REG_STAT, 32'h0000_01FF);
      repeat (3) @(posedge clk_sys);
      `CHK(irq, 1'b0)
      // Whole protection lower line inverted, data pair selected
      fault <= 2'd2;
      frames(2);
      `CHK(trib_a_tx, 14'h15A2)
      fault <= 2'd0;
      // Service clock dies, framing follows the protection copy
      trib_a_rx <= 14'h0F0F;
      wr(`SRI_REG_CTRL, 32'h0000_0007);
      svc_run <= 1'b0;
      frames(3);
      rd(`SRI_REG_LIVE); `CHK(rv[1:0], 2'b01)
      rd(`SRI_REG_STAT); `CHK(rv[0], 1'b1)
      `CHK(trib_a_tx, 14'h0F0F)
      sync_run <= 1'b0;
      frames(3);
      rd(`SRI_REG_LIVE); `CHK(rv[3], 1'b1)
      {svc_run, sync_run} <= 2'b11;
      frames(3);
      rd(`SRI_REG_LIVE); `CHK(rv[3:0], 4'h0)
      close_out();
   end
endmodule
